// [hdl/pmm_map.sv]
`timescale 1ns/1ps
`default_nettype none

module pmm_map
   import pmm_pkg::*;
#(
   parameter pmm_size_t SIZE = PMM_SIZE_64K
) (
   input  wire logic          clk,        // System clock
   input  wire logic          sys_rst,    // Async reset, active high
   input  wire pmm_pkg::pmm_req_t req,    // Request from the core
   output pmm_pkg::pmm_rsp_t  rsp,        // Answer to the core
   output pmm_pkg::pmm_dreq_t dreq,       // Forwarded data-space access
   output logic               wr_blocked, // Pulse: request of no known access kind ignored
   input  wire logic          prog_en,    // Factory programming strobe
   input  wire logic [15:0]   prog_addr,  // Programming address
   input  wire logic [7:0]    prog_data   // Programming data
);
   import pmm_pkg::*;

   // ------------------------------------------------------------
   // Program space layout
   // ------------------------------------------------------------
   // All variants share one 64 kB code space; the user code end and
   // the top of the implemented store move. Eight information bytes sit at the
   // very top, counted down from the top address:
   //
   //    top - 0 .. top - 3   serial number, four bytes
   //    top - 4              temp_offset_low_byte
   //    top - 5              temp_offset_high_byte
   //    top - 6              derivative identifier
   //    top - 7              security byte
   //
   // Below the security byte lies a reserved stretch, and below
   // that the user code:
   //
   //    16k   user 0000..3DFF   reserved 3E00..3FF7   top 3FFF
   //    32k   user 0000..7FFF   reserved 8000..FFF7   top FFFF
   //    64k   user 0000..FDFF   reserved FE00..FFF7   top FFFF
   //
   // The 32k part keeps the 64k top, so its information bytes sit
   // where firmware for the larger part looks for them.
   // Addresses past the top of the 16k part read as zero and are
   // flagged, so a runaway fetch is visible to the core.

   // ------------------------------------------------------------
   // Map limits per variant
   // ------------------------------------------------------------
   // size selects map
   localparam logic [15:0] TOP       = (SIZE == PMM_SIZE_16K) ? TOP_16K : TOP_64K;
   localparam logic [15:0] USER_END  = (SIZE == PMM_SIZE_16K) ? USER_END_16K :
                                       (SIZE == PMM_SIZE_32K) ? USER_END_32K :
                                                                USER_END_64K;
   localparam logic [15:0] INFO_BASE = TOP - OFS_SECURITY;
   localparam int unsigned DEPTH     = int'(TOP) + 1;
   // Store address width; the small store needs fewer address bits
   localparam int unsigned MEM_AW    = $clog2(DEPTH);

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic [7:0]          mem_rdata;    // Store byte, one cycle late
   logic                prog_ok;      // Programming inside the store
   logic                above_top;    // Address past the store
   logic                in_user;      // Address in user code
   logic                below_info;   // Address under the security byte
   pmm_region_t         region;       // Region of the current address
   pmm_region_t         region_reg;   // Region of the read in flight
   pmm_region_t         region_next;
   logic                pend_reg;     // Program read in flight
   logic                pend_next;
   pmm_rsp_t            rsp_next;
   pmm_dreq_t           dreq_next;
   logic                wrb_next;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // full 16-bit decode
   assign above_top  = (req.addr > TOP);
   assign in_user    = (req.addr <= USER_END);
   assign below_info = (req.addr < INFO_BASE);

   // Past-the-top is tested first; the other tests only make sense
   // for an address inside the store
   always_comb begin
      if (above_top) begin
         region = PMM_REG_UNIMPL;
      end else if (in_user) begin
         region = PMM_REG_USER;
      end else if (below_info) begin
         region = PMM_REG_RESERVED;
      end else begin
         region = PMM_REG_INFO;
      end
   end

   // ------------------------------------------------------------
   // Program store
   // ------------------------------------------------------------
   // Programming past the store would alias onto low addresses once
   // the address is cut to the store width, so it is dropped here
   assign prog_ok = prog_en && (prog_addr <= TOP);

   pmm_otp_mem #(
      .DEPTH  (DEPTH),
      .ADDR_W (MEM_AW)
   ) u_mem (
      .clk       (clk),
      .rd_addr   (req.addr[MEM_AW-1:0]),
      .rd_data   (mem_rdata),
      .prog_en   (prog_ok),
      .prog_addr (prog_addr[MEM_AW-1:0]),
      .prog_data (prog_data)
   );

   // ------------------------------------------------------------
   // Program read answer
   // ------------------------------------------------------------
   // Store data lands one cycle after the address, so the region is
   // carried along in a register and the answer leaves one cycle
   // later still: two cycles from request to answer
   always_comb begin
      pend_next   = 1'b0;
      region_next = region;
      rsp_next    = '0;
      // Answer the read taken last cycle
      if (pend_reg) begin
         rsp_next.valid = 1'b1;
         // info bytes read as stored constants
         rsp_next.rdata = (region_reg == PMM_REG_UNIMPL) ? UNIMPL_BYTE : mem_rdata;
         rsp_next.reserved_hit = (region_reg == PMM_REG_RESERVED) ||
                                 (region_reg == PMM_REG_UNIMPL);
      end
      // fetch and constant read use program space
      if (req.valid && (req.kind == PMM_ACC_FETCH || req.kind == PMM_ACC_CONST)) begin
         pend_next = 1'b1;
      end
   end

   // Answer registers; reserved reads keep the stored byte visible
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rsp        <= '0;
         pend_reg   <= 1'b0;
         region_reg <= PMM_REG_USER;
      end else begin
         rsp        <= rsp_next;
         pend_reg   <= pend_next;
         region_reg <= region_next;
      end
   end

   // ------------------------------------------------------------
   // Data-space forward
   // ------------------------------------------------------------
   // data-space access forwarded, never touches code
   // Writes have no path into the store at all: program memory only
   // changes through the factory programming port
   always_comb begin
      dreq_next = '0;
      wrb_next  = 1'b0;
      if (req.valid) begin
         case (req.kind)
            PMM_ACC_FETCH,
            PMM_ACC_CONST: begin
               // Program space, answered above
            end
            PMM_ACC_DATA_RD: begin
               dreq_next.valid = 1'b1;
               dreq_next.addr  = req.addr;
            end
            // writes go to data space only
            PMM_ACC_DATA_WR: begin
               dreq_next.valid = 1'b1;
               dreq_next.write = 1'b1;
               dreq_next.addr  = req.addr;
               dreq_next.wdata = req.wdata;
            end
            default: begin
               wrb_next = 1'b1;
            end
         endcase
      end
   end

   // Forward registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dreq       <= '0;
         wr_blocked <= 1'b0;
      end else begin
         dreq       <= dreq_next;
         wr_blocked <= wrb_next;
      end
   end

endmodule

`default_nettype wire

// [hdl/pmm_pkg.sv]
`default_nettype none
package pmm_pkg;

   // ------------------------------------------------------------
   // Address space and variants
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned SPACE_SIZE = 65536;

   typedef enum logic [1:0] {
      PMM_SIZE_16K,
      PMM_SIZE_32K,
      PMM_SIZE_64K
   } pmm_size_t;

   // Top of the implemented space for each variant
   localparam logic [15:0] TOP_16K = 16'h3FFF;
   localparam logic [15:0] TOP_64K = 16'hFFFF;
   // User code limits
   localparam logic [15:0] USER_END_16K = 16'h3DFF;
   localparam logic [15:0] USER_END_32K = 16'h7FFF;
   localparam logic [15:0] USER_END_64K = 16'hFDFF;
   // Offsets of the information bytes below the top
   localparam logic [15:0] OFS_SECURITY = 16'h0007;
   localparam logic [15:0] OFS_DERIV_ID = 16'h0006;
   localparam logic [15:0] OFS_TOFF_HI  = 16'h0005;
   localparam logic [15:0] OFS_TOFF_LO  = 16'h0004;
   localparam logic [15:0] OFS_SERIAL   = 16'h0003;
   // Byte values the store shows without a programmed cell
   localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
   localparam logic [7:0]  UNIMPL_BYTE  = 8'h00;

   // Access kinds, chosen by the instruction type
   typedef enum logic [1:0] {
      PMM_ACC_FETCH,
      PMM_ACC_CONST,
      PMM_ACC_DATA_RD,
      PMM_ACC_DATA_WR
   } pmm_acc_t;

   // Region of an address
   typedef enum logic [2:0] {
      PMM_REG_USER,
      PMM_REG_RESERVED,
      PMM_REG_INFO,
      PMM_REG_UNIMPL
   } pmm_region_t;

   // Request from the core
   typedef struct packed {
      logic              valid;
      pmm_acc_t          kind;
      logic [15:0]       addr;
      logic [7:0]        wdata;
   } pmm_req_t;

   // Answer to the core
   typedef struct packed {
      logic              valid;
      logic [7:0]        rdata;
      logic              reserved_hit;
   } pmm_rsp_t;

   // Data memory side request
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [15:0]       addr;
      logic [7:0]        wdata;
   } pmm_dreq_t;

endpackage
`default_nettype wire

// [hdl/pmm_otp_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module pmm_otp_mem #(
   parameter int unsigned DEPTH  = 65536,
   parameter int unsigned ADDR_W = 16
) (
   input  wire logic              clk,       // System clock
   input  wire logic [ADDR_W-1:0] rd_addr,   // Read address
   output logic [7:0]             rd_data,   // Registered read data
   input  wire logic              prog_en,   // Factory programming strobe
   input  wire logic [ADDR_W-1:0] prog_addr, // Programming address
   input  wire logic [7:0]        prog_data  // Bits to program
);

   // Blank cells read all ones, so the first programming pass lands
   // its own bits instead of an unknown
   logic [7:0] mem [DEPTH] = '{default: pmm_pkg::ERASED_BYTE};

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // One-time cells only clear bits; erased value is all ones
   always_ff @(posedge clk) begin
      if (prog_en) begin
         mem[prog_addr] <= mem[prog_addr] & prog_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule

`default_nettype wire

// [test/pmm_map_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module pmm_map_asserts
   import pmm_pkg::*;
#(parameter pmm_size_t SIZE = PMM_SIZE_64K) (
   input wire logic           clk,       // Clock
   input wire logic           sys_rst,   // Reset
   input wire pmm_pkg::pmm_req_t  req,   // Request
   input wire pmm_pkg::pmm_rsp_t  rsp,   // Answer
   input wire pmm_pkg::pmm_dreq_t dreq,  // Data forward
   input wire logic           wr_blocked // Ignored request of unknown kind
);
   // ----------------------------------------
   // Map limits of the variant
   // ----------------------------------------
   localparam logic [15:0] TOP = (SIZE == PMM_SIZE_16K) ? TOP_16K : TOP_64K;
   localparam logic [15:0] UE = (SIZE == PMM_SIZE_16K) ? USER_END_16K :
                                (SIZE == PMM_SIZE_32K) ? USER_END_32K : USER_END_64K;
   localparam logic [15:0] INF = TOP - OFS_SECURITY;
   wire logic rd = req.valid && !req.kind[1];
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_read_answer: assert property (rd |-> ##2 rsp.valid) else $error("no answer");
   a_answer_cause: assert property (rsp.valid |-> $past(rd, 2)) else $error("stray answer");
   a_data_route: assert property (req.valid && req.kind[1] |=> dreq.valid
      && dreq.addr == $past(req.addr)) else $error("data not forwarded");
   a_write_fwd: assert property (req.valid && req.kind == PMM_ACC_DATA_WR |=> dreq.write
      && dreq.wdata == $past(req.wdata)) else $error("write not forwarded");
   a_never_blocked: assert property (!wr_blocked) else $error("blocked pulse");
   a_user_clean: assert property (rd && req.addr <= UE |-> ##2 !rsp.reserved_hit)
      else $error("user flagged");
   a_resv_flag: assert property (rd && req.addr > UE && req.addr < INF
      |-> ##2 rsp.reserved_hit) else $error("reserved unflagged");
   a_info_clean: assert property (rd && req.addr >= INF && req.addr <= TOP
      |-> ##2 !rsp.reserved_hit) else $error("info flagged");
   a_unimpl_zero: assert property (rd && req.addr > TOP
      |-> ##2 rsp.reserved_hit && rsp.rdata == 8'h00) else $error("unimpl read");
endmodule
bind pmm_map pmm_map_asserts #(.SIZE(SIZE)) pmm_map_asserts_i (.clk(clk), .sys_rst(sys_rst),
   .req(req), .rsp(rsp), .dreq(dreq), .wr_blocked(wr_blocked));
`default_nettype wire

// [test/pmm_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmm_core_model
   import pmm_pkg::*;
(
   input wire logic          clk, // Clock
   output pmm_pkg::pmm_req_t req  // Request to the map
);
   initial req = '0;
   task automatic send(input pmm_acc_t k, input logic [15:0] a, input logic [7:0] d);
      req = '{1'b1, k, a, d};
      @(negedge clk);
   endtask
   // Idle bus shows inverted leftovers, never a stale address
   task automatic idle();
      req = '{1'b0, req.kind, ~req.addr, ~req.wdata};
      @(negedge clk);
   endtask
endmodule
`default_nettype wire

// [test/pmm_map_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pmm_map_tb_top;
   import pmm_pkg::*;
   logic       clk, sys_rst, prog_en, wr_blocked;
   logic [15:0] prog_addr;
   logic [7:0] prog_data, wd;
   logic [7:0] mem [logic [15:0]];
   pmm_req_t   req;
   pmm_rsp_t   rsp, rsp64;
   pmm_dreq_t  dreq;
   logic [8:0] rq [$], rq64 [$], ex;
   pmm_dreq_t  dq [$];
   int         fails = 0, n_tests = 0, seed = 72008, cyc = 0;
   logic [15:0] al [$] = '{16'h0000, 16'h3DFF, 16'h3E00, 16'h3FF7, 16'h3FF8, 16'h3FF9,
                          16'h3FFA, 16'h3FFB, 16'h3FFC, 16'h3FFD, 16'h3FFE, 16'h3FFF};
   pmm_map #(.SIZE(PMM_SIZE_16K)) pmm_map_i (.clk(clk), .sys_rst(sys_rst), .req(req),
      .rsp(rsp), .dreq(dreq), .wr_blocked(wr_blocked), .prog_en(prog_en),
      .prog_addr(prog_addr), .prog_data(prog_data));
   // Large variant on the same request stream
   pmm_map #(.SIZE(PMM_SIZE_64K)) pmm_map_64k_i (.clk(clk), .sys_rst(sys_rst), .req(req),
      .rsp(rsp64), .dreq(), .wr_blocked(), .prog_en(prog_en),
      .prog_addr(prog_addr), .prog_data(prog_data));
   pmm_core_model pmm_core_model_i (.clk(clk), .req(req));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // ----------------------------------------
   // Compare, verdict, expected reads
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Unimplemented reads give zero, reserved ones keep stored byte
   task automatic rd(input pmm_acc_t k, input logic [15:0] a);
      logic       h;
      logic [7:0] b;
      h = (a > TOP_16K) || (a > USER_END_16K && a < 16'h3FF8);
      b = mem.exists(a) ? mem[a] : 8'hFF;
      rq.push_back({(a > TOP_16K) ? 8'h00 : b, h});
      // Large part: unprogrammed cells read erased
      rq64.push_back({b, (a > USER_END_64K && a < 16'hFFF8)});
      pmm_core_model_i.send(k, a, 8'h00);
   endtask
   // Monitor takes the oldest note whenever a result shows
   always @(negedge clk) begin
      if (rsp.valid === 1'b1) begin
         ex = rq.size() ? rq.pop_front() : 'x;
         check("rsp", {rsp.rdata, rsp.reserved_hit}, ex);
      end
      if (rsp64.valid === 1'b1) begin
         ex = rq64.size() ? rq64.pop_front() : 'x;
         check("rsp64", {rsp64.rdata, rsp64.reserved_hit}, ex);
      end
      if (dreq.valid === 1'b1) check("dreq", dreq, dq.size() ? dq.pop_front() : 'x);
      if (wr_blocked !== 1'b0) check("wr_blocked", wr_blocked, 1'b0);
      cyc++;
      if (cyc == 3000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      sys_rst = 1;
      prog_en = 0;
      prog_addr = '0;
      prog_data = '0;
      repeat (5) @(negedge clk);
      sys_rst = 0;
      @(negedge clk);
      foreach (al[i]) begin
         prog_en = 1;
         prog_addr = al[i];
         prog_data = $random(seed);
         mem[al[i]] = prog_data;
         @(negedge clk);
      end
      // Programming a byte again can only clear more bits
      prog_addr = 16'h0000;
      prog_data = $random(seed);
      mem[16'h0000] = mem[16'h0000] & prog_data;
      @(negedge clk);
      prog_en = 0;
      repeat (4) @(negedge clk);
      $display("test program done");
      // Back to back reads over every region
      foreach (al[i]) rd(PMM_ACC_CONST, al[i]);
      rd(PMM_ACC_FETCH, 16'h0000);
      rd(PMM_ACC_CONST, 16'h4000);
      rd(PMM_ACC_FETCH, 16'hFFFF);
      rd(PMM_ACC_CONST, 16'hFDFF);
      rd(PMM_ACC_CONST, 16'hFE00);
      pmm_core_model_i.idle();
      $display("test reads done");
      // Same address to data space must not touch program bytes
      wd = $random(seed);
      dq.push_back('{1'b1, 1'b1, 16'h3FF8, wd});
      pmm_core_model_i.send(PMM_ACC_DATA_WR, 16'h3FF8, wd);
      dq.push_back('{1'b1, 1'b0, 16'h0000, 8'h00});
      pmm_core_model_i.send(PMM_ACC_DATA_RD, 16'h0000, ~wd);
      rd(PMM_ACC_CONST, 16'h3FF8);
      pmm_core_model_i.idle();
      repeat (4) @(negedge clk);
      check("pending", rq.size() + rq64.size() + dq.size(), 0);
      $display("test data route done");
      conclude();
   end
endmodule
`default_nettype wire
